/* File: dv/pin_partner.sv */
// board side of the two ports: resolves port drive against board drive
`timescale 1ns/1ps
module pin_partner (
   input  wire logic [7:0] i_out7,
   input  wire logic [7:0] i_oe7,
   input  wire logic [7:0] i_drv7,
   input  wire logic [7:0] i_out8,
   input  wire logic [7:0] i_oe8,
   input  wire logic [7:0] i_drv8,
   output logic      [7:0] o_lvl7,
   output logic      [7:0] o_lvl8
);
   // board drives only pins that the port leaves free
   assign o_lvl7 = (i_oe7 & i_out7) | (~i_oe7 & i_drv7);
   assign o_lvl8 = (i_oe8 & i_out8) | (~i_oe8 & i_drv8);
endmodule : pin_partner

/* File: dv/tb_top.sv */
// self-checking bench for the lcd-shared port pair
`timescale 1ns/1ps
module tb_top;
   import lcd_gpio_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst     = 1'b1;
   logic        cyc     = 1'b0;
   logic        stb     = 1'b0;
   logic        we      = 1'b0;
   logic [31:0] adr     = 32'h0000_0000;
   logic [3:0]  sel     = 4'h0;
   logic [31:0] wdat    = 32'h0000_0000;
   logic [31:0] rdat;
   logic        ack;
   power_mode_t mode    = MODE_ACTIVE;
   logic [15:0] col     = 16'h0000;
   logic [3:0]  xs      = 4'h0;
   logic [7:0]  p7i, p7o, p7e, p8i, p8o, p8e;
   logic [7:0]  drv7    = 8'h00;
   logic [7:0]  drv8    = 8'h00;
   logic [7:0]  d7, r7, d8, r8;
   logic [3:0]  s;
   logic        x;
   logic [31:0] hold;
   int          num_errors = 0;
   int          n_compared = 0;
   int          cycles     = 0;

   always #4 clk_sys = ~clk_sys;

   lcd_gpio_ports dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_power_mode(mode), .i_lcd_column_output(col),
      .i_lcd_latch_clock_first(xs[3]), .i_lcd_shift_clock_second(xs[2]),
      .i_lcd_shift_data(xs[1]), .i_lcd_alternation(xs[0]), .i_first_port_pin(p7i),
      .o_first_port_pin(p7o), .o_first_port_pin_oe(p7e), .i_second_port_pin(p8i),
      .o_second_port_pin(p8o), .o_second_port_pin_oe(p8e));

   pin_partner pins (.i_out7(p7o), .i_oe7(p7e), .i_drv7(drv7), .i_out8(p8o), .i_oe8(p8e),
      .i_drv8(drv8), .o_lvl7(p7i), .o_lvl8(p8i));

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         end_sim();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d,
                     input logic [3:0] sl, output logic [31:0] rd);
      @(posedge clk_sys);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      sel  <= sl;
      adr  <= {14'h0000, idx, 2'b00};
      wdat <= {24'h00_0000, d};
      // no local limit: only the bench timeout ends a hung cycle
      do begin
         @(posedge clk_sys);
      end while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : wb

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [31:0] r;
      wb(1'b1, idx, d, 4'hf, r);
   endtask : wr

   task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input string what);
      logic [31:0] r;
      wb(1'b0, idx, 8'h00, 4'hf, r);
      check(r, exp, what);
   endtask : rdchk

   // {oe8, out8 & oe8, oe7, out7 & oe7} from the current settings
   function automatic logic [31:0] pins_exp();
      logic [7:0] o7, e7, o8, e8;
      logic       own7, own8;
      own7 = |s[3:2];
      own8 = |s[3:1];
      e7 = own7 ? 8'hff : r7;
      o7 = own7 ? col[7:0] : d7;
      e8 = own8 ? 8'hff : r8;
      o8 = own8 ? col[15:8] : d8;
      if (x) begin
         e8[7:4] = 4'hf;
         o8[7:4] = xs;
      end
      return {e8, o8 & e8, e7, o7 & e7};
   endfunction : pins_exp

   function automatic logic [31:0] seen();
      return {p8e, p8o & p8e, p7e, p7o & p7e};
   endfunction : seen

   task automatic cfg();
      wr(LCD_CTRL_IDX, {3'b000, x, s});
      wr(PORT7_DATA_IDX, d7);
      wr(PORT7_DIR_IDX, r7);
      wr(PORT8_DATA_IDX, d8);
      wr(PORT8_DIR_IDX, r8);
      repeat (4) @(posedge clk_sys);
   endtask : cfg

   task automatic draw();
      d7 = 8'($urandom);
      r7 = 8'($urandom);
      d8 = 8'($urandom);
      r8 = 8'($urandom);
      drv7 <= 8'($urandom);
      drv8 <= 8'($urandom);
      col  <= 16'($urandom);
      xs   <= 4'($urandom);
   endtask : draw

   task automatic read_chk();
      logic [31:0] e;
      logic [7:0]  l7, l8;
      e  = pins_exp();
      l7 = e[7:0] | (~e[15:8] & drv7);
      l8 = e[23:16] | (~e[31:24] & drv8);
      rdchk(PORT7_DATA_IDX, {24'h00_0000, (r7 & d7) | (~r7 & l7)}, "port7 read");
      rdchk(PORT8_DATA_IDX, {24'h00_0000, (r8 & d8) | (~r8 & l8)}, "port8 read");
   endtask : read_chk

   initial begin
      logic [31:0] r;
      power_mode_t hm [3];
      hm = '{MODE_SLEEP, MODE_SUBSLEEP, MODE_WATCH};
      void'($urandom(32'hf3f0));
      repeat (19) @(posedge clk_sys);
      check({p8e, p7e}, 32'h0000_0000, "oe during reset");
      @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      check({p8e, p7e}, 32'h0000_0000, "oe after reset");
      rdchk(PORT7_DIR_IDX, 32'h0000_00ff, "port7 dir read");
      rdchk(PORT8_DIR_IDX, 32'h0000_00ff, "port8 dir read");
      wr(PORT7_DIR_IDX, 8'hff);
      wr(PORT8_DIR_IDX, 8'hff);
      rdchk(PORT7_DATA_IDX, 32'h0000_0000, "port7 latch reset");
      rdchk(PORT8_DATA_IDX, 32'h0000_0000, "port8 latch reset");
      rdchk(16'hffd0, UNMAPPED_VAL, "unmapped read");
      // every select code with and without the external driver
      for (int i = 0; i < 32; i++) begin
         s = i[3:0];
         x = i[4];
         mode <= i[0] ? MODE_SUBACTIVE : MODE_ACTIVE;
         draw();
         cfg();
         check(seen(), pins_exp(), "pin function");
         check(seen(), pins_exp(), "lcd owned");
         read_chk();
         rdchk(PORT8_DIR_IDX, 32'h0000_00ff, "dir read after write");
      end
      // byte lane 0 off: write must be dropped
      wb(1'b1, PORT7_DATA_IDX, ~d7, 4'he, r);
      read_chk();
      s = 4'h0;
      x = 1'b0;
      for (int m = 0; m < 3; m++) begin
         draw();
         cfg();
         hold = pins_exp();
         mode <= hm[m];
         draw();
         cfg();
         check(seen(), hold, "pins held");
         mode <= MODE_ACTIVE;
         repeat (3) @(posedge clk_sys);
         check(seen(), pins_exp(), "pins resume");
      end
      mode <= MODE_STANDBY;
      repeat (3) @(posedge clk_sys);
      check(seen(), 32'h0000_0000, "standby float");
      mode <= MODE_ACTIVE;
      rst  <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check({p8e, p7e}, 32'h0000_0000, "dir after mid reset");
      wr(PORT7_DIR_IDX, 8'hff);
      wr(PORT8_DIR_IDX, 8'hff);
      rdchk(PORT7_DATA_IDX, 32'h0000_0000, "port7 latch mid reset");
      rdchk(PORT8_DATA_IDX, 32'h0000_0000, "port8 latch mid reset");
      end_sim();
   end
endmodule : tb_top

/* File: logic/lcd_gpio_pkg.sv */
// constants and types shared by the lcd-shared port pair
package lcd_gpio_pkg;

   // register word indices; byte address is four times the index
   localparam logic [15:0] PORT7_DATA_IDX = 16'hffda;
   localparam logic [15:0] PORT8_DATA_IDX = 16'hffdb;
   localparam logic [15:0] PORT7_DIR_IDX  = 16'hffea;
   localparam logic [15:0] PORT8_DIR_IDX  = 16'hffeb;
   localparam logic [15:0] LCD_CTRL_IDX   = 16'hffc0;

   // lcd_port_control field layout
   localparam int LCD_SEL_LSB  = 0;
   localparam int LCD_SEL_W    = 4;
   localparam int LCD_EXT_BIT  = 4;

   // values after reset and fixed read values
   localparam logic [7:0]  PORT_DATA_RST = 8'h00;
   localparam logic [7:0]  PORT_DIR_RST  = 8'h00;
   localparam logic [3:0]  LCD_SEL_RST   = 4'h0;
   localparam logic [7:0]  DIR_READ_VAL  = 8'hff;
   localparam logic [31:0] UNMAPPED_VAL  = 32'h0000_0000;

   // first lcd column on each port pin 0
   localparam int P7_COL_BASE = 17;
   localparam int P8_COL_BASE = 25;
   localparam int COL_LOW     = 17;

   typedef enum logic [5:0] {
      MODE_ACTIVE    = 6'b00_0001,
      MODE_SUBACTIVE = 6'b00_0010,
      MODE_SLEEP     = 6'b00_0100,
      MODE_SUBSLEEP  = 6'b00_1000,
      MODE_WATCH     = 6'b01_0000,
      MODE_STANDBY   = 6'b10_0000
   } power_mode_t;

endpackage : lcd_gpio_pkg

/* File: logic/lcd_gpio_ports.sv */
// two lcd-shared gpio ports with a classic wishbone slave
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
module lcd_gpio_ports
   import lcd_gpio_pkg::*;
(
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_rst,
   input  wire logic                      i_wb_cyc,
   input  wire logic                      i_wb_stb,
   input  wire logic                      i_wb_we,
   input  wire logic [31:0]               i_wb_adr,
   input  wire logic [3:0]                i_wb_sel,
   input  wire logic [31:0]               i_wb_dat,
   output logic      [31:0]               o_wb_dat,
   output logic                           o_wb_ack,
   input  wire lcd_gpio_pkg::power_mode_t i_power_mode,
   input  wire logic [15:0]               i_lcd_column_output,
   input  wire logic                      i_lcd_latch_clock_first,
   input  wire logic                      i_lcd_shift_clock_second,
   input  wire logic                      i_lcd_shift_data,
   input  wire logic                      i_lcd_alternation,
   input  wire logic [7:0]                i_first_port_pin,
   output logic      [7:0]                o_first_port_pin,
   output logic      [7:0]                o_first_port_pin_oe,
   input  wire logic [7:0]                i_second_port_pin,
   output logic      [7:0]                o_second_port_pin,
   output logic      [7:0]                o_second_port_pin_oe
);
   import lcd_gpio_pkg::*;

   logic [7:0] port7_data_latch;
   logic [7:0] port7_direction_bits;
   logic [7:0] port8_data_latch;
   logic [7:0] port8_direction_bits;
   logic [3:0] lcd_column_select_field;
   logic       lcd_external_driver_select;
   logic [7:0] p7_pin_sync;
   logic [7:0] p8_pin_sync;
   logic       req;
   logic       wr_now;
   logic [31:0] rd_next;
   logic [7:0] p7_read;
   logic [7:0] p8_read;
   logic       pins_hold;
   logic       pins_float;

   pin_mux_if mux_bus ();

   // word hit: upper address bits clear, word index matches
   function automatic logic reg_hit(input logic [31:0] adr,
                                    input logic [15:0] idx);
      reg_hit = (adr[31:18] == 14'h0000) && (adr[17:2] == idx);
   endfunction : reg_hit

   pin_sync2 #(.W(8)) u_sync7 (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_async   (i_first_port_pin),
      .o_sync    (p7_pin_sync)
   );

   pin_sync2 #(.W(8)) u_sync8 (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_async   (i_second_port_pin),
      .o_sync    (p8_pin_sync)
   );

   assign mux_bus.p7_data = port7_data_latch;
   assign mux_bus.p7_dir  = port7_direction_bits;
   assign mux_bus.p8_data = port8_data_latch;
   assign mux_bus.p8_dir  = port8_direction_bits;
   assign mux_bus.col_sel = lcd_column_select_field;
   assign mux_bus.ext_sel = lcd_external_driver_select;
   assign mux_bus.lcd_col = i_lcd_column_output;
   assign mux_bus.ext_sig = {i_lcd_latch_clock_first, i_lcd_shift_clock_second,
                             i_lcd_shift_data, i_lcd_alternation};

   lcd_pin_mux u_mux (
      .bus (mux_bus.mux)
   );

   // bus handshake: ack one cycle after request, write on acked edge
   assign req    = i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign wr_now = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_sel[0];

   assign p7_read = (port7_direction_bits & port7_data_latch)
                  | (~port7_direction_bits & p7_pin_sync);
   assign p8_read = (port8_direction_bits & port8_data_latch)
                  | (~port8_direction_bits & p8_pin_sync);

   always_comb begin
      rd_next = UNMAPPED_VAL;
      if (reg_hit(i_wb_adr, PORT7_DATA_IDX)) begin
         rd_next = {24'h00_0000, p7_read};
      end else if (reg_hit(i_wb_adr, PORT8_DATA_IDX)) begin
         rd_next = {24'h00_0000, p8_read};
      end else if (reg_hit(i_wb_adr, PORT7_DIR_IDX)) begin
         rd_next = {24'h00_0000, DIR_READ_VAL};
      end else if (reg_hit(i_wb_adr, PORT8_DIR_IDX)) begin
         rd_next = {24'h00_0000, DIR_READ_VAL};
      end else if (reg_hit(i_wb_adr, LCD_CTRL_IDX)) begin
         rd_next = {27'h000_0000, lcd_external_driver_select,
                    lcd_column_select_field};
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= UNMAPPED_VAL;
      end else begin
         o_wb_ack <= req;
         if (req && !i_wb_we) begin
            o_wb_dat <= rd_next;
         end
      end
   end

   // first port registers
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         port7_data_latch     <= PORT_DATA_RST;
         port7_direction_bits <= PORT_DIR_RST;
      end else if (wr_now && reg_hit(i_wb_adr, PORT7_DATA_IDX)) begin
         port7_data_latch <= i_wb_dat[7:0];
      end else if (wr_now && reg_hit(i_wb_adr, PORT7_DIR_IDX)) begin
         port7_direction_bits <= i_wb_dat[7:0];
      end
   end

   // second port registers, one bit per pin
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         port8_data_latch     <= PORT_DATA_RST;
         port8_direction_bits <= PORT_DIR_RST;
      end else if (wr_now && reg_hit(i_wb_adr, PORT8_DATA_IDX)) begin
         port8_data_latch <= i_wb_dat[7:0];
      end else if (wr_now && reg_hit(i_wb_adr, PORT8_DIR_IDX)) begin
         port8_direction_bits <= i_wb_dat[7:0];
      end
   end

   // pin-ownership control
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         lcd_column_select_field    <= LCD_SEL_RST;
         lcd_external_driver_select <= 1'b0;
      end else if (wr_now && reg_hit(i_wb_adr, LCD_CTRL_IDX)) begin
         lcd_column_select_field    <= i_wb_dat[LCD_SEL_LSB +: LCD_SEL_W];
         lcd_external_driver_select <= i_wb_dat[LCD_EXT_BIT];
      end
   end

   // power-mode decode; unknown codes float the pins
   always_comb begin
      pins_hold  = 1'b0;
      pins_float = 1'b0;
      unique case (i_power_mode)
         MODE_ACTIVE,
         MODE_SUBACTIVE: begin
            pins_hold = 1'b0;
         end
         MODE_SLEEP,
         MODE_SUBSLEEP,
         MODE_WATCH: begin
            pins_hold = 1'b1;
         end
         MODE_STANDBY: begin
            pins_float = 1'b1;
         end
         default: begin
            pins_float = 1'b1;
         end
      endcase
   end

   // pin drivers; lcd-owned pins take the lcd value from the selector
   always_ff @(posedge i_clk_sys) begin
      if (i_rst || pins_float) begin
         o_first_port_pin    <= PORT_DATA_RST;
         o_first_port_pin_oe <= 8'h00;
      end else if (!pins_hold) begin
         o_first_port_pin    <= mux_bus.p7_out;
         o_first_port_pin_oe <= mux_bus.p7_oe;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst || pins_float) begin
         o_second_port_pin    <= PORT_DATA_RST;
         o_second_port_pin_oe <= 8'h00;
      end else if (!pins_hold) begin
         o_second_port_pin    <= mux_bus.p8_out;
         o_second_port_pin_oe <= mux_bus.p8_oe;
      end
   end

   // checks
   logic run;
   logic seg7;
   logic seg8;
   assign run  = (i_power_mode == MODE_ACTIVE) || (i_power_mode == MODE_SUBACTIVE);
   assign seg7 = lcd_column_select_field[3] | lcd_column_select_field[2];
   assign seg8 = seg7 | lcd_column_select_field[1];

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   a_p7_read_mix: assert property (
      req && !i_wb_we && reg_hit(i_wb_adr, PORT7_DATA_IDX)
      |=> o_wb_ack && o_wb_dat[7:0] == (($past(port7_direction_bits)
          & $past(port7_data_latch)) | (~$past(port7_direction_bits)
          & $past(p7_pin_sync))))
      else $error("first port read mix wrong");

   a_p7_io_drive: assert property (
      run && !seg7 ##1 run |-> o_first_port_pin_oe == $past(port7_direction_bits)
      && o_first_port_pin == $past(port7_data_latch))
      else $error("first port gpio drive wrong");

   a_p7_dir_ones: assert property (
      req && !i_wb_we && reg_hit(i_wb_adr, PORT7_DIR_IDX)
      |=> o_wb_dat == 32'h0000_00ff)
      else $error("first port direction read not all ones");

   a_p7_reset_clear: assert property (
      $past(i_rst) |-> port7_data_latch == 8'h00
      && port7_direction_bits == 8'h00)
      else $error("first port not cleared by reset");

   a_p7_lcd_own: assert property (
      run && seg7 |=> o_first_port_pin_oe == 8'hff
      && o_first_port_pin == $past(i_lcd_column_output[7:0]))
      else $error("first port lcd column not routed");

   a_p7_mode_pins: assert property (
      i_power_mode == MODE_STANDBY |=> o_first_port_pin_oe == 8'h00)
      else $error("first port not floating in standby");

   a_p7_subsleep_hold: assert property (
      i_power_mode == MODE_SUBSLEEP |=> $stable(o_first_port_pin)
      && $stable(o_first_port_pin_oe))
      else $error("first port changed in subsleep");

   a_p8_read_mix: assert property (
      req && !i_wb_we && reg_hit(i_wb_adr, PORT8_DATA_IDX)
      |=> o_wb_ack && o_wb_dat[7:0] == (($past(port8_direction_bits)
          & $past(port8_data_latch)) | (~$past(port8_direction_bits)
          & $past(p8_pin_sync))))
      else $error("second port read mix wrong");

   a_p8_io_drive: assert property (
      run && !seg8 && !lcd_external_driver_select
      |=> o_second_port_pin_oe == $past(port8_direction_bits)
      && o_second_port_pin == $past(port8_data_latch))
      else $error("second port gpio drive wrong");

   a_p8_dir_ones: assert property (
      req && !i_wb_we && reg_hit(i_wb_adr, PORT8_DIR_IDX)
      |=> o_wb_dat == 32'h0000_00ff)
      else $error("second port direction read not all ones");

   a_p8_reset_clear: assert property (
      $past(i_rst) |-> port8_data_latch == 8'h00
      && port8_direction_bits == 8'h00)
      else $error("second port not cleared by reset");

   a_p8_top_pin: assert property (
      run && lcd_external_driver_select |=> o_second_port_pin_oe[7]
      && o_second_port_pin[7] == $past(i_lcd_latch_clock_first))
      else $error("latch clock not on top pin");

   a_p8_mid_pins: assert property (
      run && lcd_external_driver_select |=> o_second_port_pin[6:4]
      == {$past(i_lcd_shift_clock_second), $past(i_lcd_shift_data),
          $past(i_lcd_alternation)})
      else $error("driver signals not on pins 6 to 4");

   a_p8_low_cols: assert property (
      run && seg8 |=> o_second_port_pin_oe[3:0] == 4'hf
      && o_second_port_pin[3:0] == $past(i_lcd_column_output[11:8]))
      else $error("columns 25 to 28 not routed");

   a_p8_sleep_hold: assert property (
      i_power_mode == MODE_SLEEP || i_power_mode == MODE_WATCH
      |=> $stable(o_second_port_pin) && $stable(o_second_port_pin_oe))
      else $error("second port changed while held");

   a_p8_standby_hiz: assert property (
      i_power_mode == MODE_STANDBY |=> o_second_port_pin_oe == 8'h00)
      else $error("second port not floating in standby");

   a_p8_subsleep_hold: assert property (
      i_power_mode == MODE_SUBSLEEP |=> $stable(o_second_port_pin)
      && $stable(o_second_port_pin_oe))
      else $error("second port changed in subsleep");

   a_reset_pins_off: assert property (
      $past(i_rst) |-> o_first_port_pin_oe == 8'h00
      && o_second_port_pin_oe == 8'h00)
      else $error("pins driven right after reset");

   a_wb_ack_pulse: assert property (
      req |=> o_wb_ack ##1 !o_wb_ack)
      else $error("ack not a single cycle one cycle after request");

endmodule : lcd_gpio_ports

/* File: logic/lcd_pin_mux.sv */
// selects, per pin, between port latch and lcd signals
`timescale 1ns/1ps
module lcd_pin_mux (
   pin_mux_if.mux bus
);
   import lcd_gpio_pkg::*;

   // first port goes to lcd for select 01** or 1***
   function automatic logic p7_is_lcd(input logic [3:0] sel);
      p7_is_lcd = sel[3] | sel[2];
   endfunction : p7_is_lcd

   // second port also for 001*
   function automatic logic p8_is_lcd(input logic [3:0] sel);
      p8_is_lcd = sel[3] | sel[2] | sel[1];
   endfunction : p8_is_lcd

   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_pin
         always_comb begin
            if (p7_is_lcd(bus.col_sel)) begin
               bus.p7_out[i] = bus.lcd_col[P7_COL_BASE - COL_LOW + i];
               bus.p7_oe[i]  = 1'b1;
            end else begin
               bus.p7_out[i] = bus.p7_data[i];
               bus.p7_oe[i]  = bus.p7_dir[i];
            end
         end
         always_comb begin
            if (i >= 4 && bus.ext_sel) begin
               bus.p8_out[i] = bus.ext_sig[(i % 4)];
               bus.p8_oe[i]  = 1'b1;
            end else if (p8_is_lcd(bus.col_sel)) begin
               bus.p8_out[i] = bus.lcd_col[P8_COL_BASE - COL_LOW + i];
               bus.p8_oe[i]  = 1'b1;
            end else begin
               bus.p8_out[i] = bus.p8_data[i];
               bus.p8_oe[i]  = bus.p8_dir[i];
            end
         end
      end
   endgenerate
endmodule : lcd_pin_mux

/* File: logic/pin_mux_if.sv */
// bundle between the register side and the pin selector
`timescale 1ns/1ps
interface pin_mux_if;
   logic [7:0]  p7_data;
   logic [7:0]  p7_dir;
   logic [7:0]  p8_data;
   logic [7:0]  p8_dir;
   logic [3:0]  col_sel;
   logic        ext_sel;
   logic [15:0] lcd_col;
   logic [3:0]  ext_sig;
   logic [7:0]  p7_out;
   logic [7:0]  p7_oe;
   logic [7:0]  p8_out;
   logic [7:0]  p8_oe;

   modport ctrl (output p7_data, p7_dir, p8_data, p8_dir, col_sel, ext_sel,
                 lcd_col, ext_sig, input p7_out, p7_oe, p8_out, p8_oe);
   modport mux  (input p7_data, p7_dir, p8_data, p8_dir, col_sel, ext_sel,
                 lcd_col, ext_sig, output p7_out, p7_oe, p8_out, p8_oe);
endinterface : pin_mux_if

/* File: logic/pin_sync2.sv */
// two-stage synchroniser for pin levels
`timescale 1ns/1ps
module pin_sync2 #(
   parameter int W = 8
) (
   input  wire logic         i_clk_sys,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         meta_reg <= '0;
         o_sync   <= '0;
      end else begin
         meta_reg <= i_async;
         o_sync   <= meta_reg;
      end
   end
endmodule : pin_sync2
